// >>> pkg/adc_out_consts.svh
// constants for the sample output path of the converter
`ifndef ADC_OUT_CONSTS_SVH
`define ADC_OUT_CONSTS_SVH

// =============================================
// widths and depths
`define WORD_W      12
`define CODE_W      14
`define LATENCY     11
`define PIPE_DEPTH  (`LATENCY - 1)
`define FIFO_DEPTH  16

// =============================================
// output coding
`define POS_FS_TWOS 12'h7ff
`define NEG_FS_TWOS 12'h800
`define MSB_FLIP    12'h800
`define CODE_POS_FS 14'h07ff
`define CODE_NEG_FS 14'h3800

// =============================================
// strap and pin inputs
`define PIN_W       3
`define PIN_HALF    0
`define PIN_FMT     1
`define PIN_RDY     2
`define PIN_RESET   3'h4

// =============================================
// clocking
`define CLK_HZ      25000000
`define MIN_CLK_HZ  20000000

`endif

// >>> pkg/adc_out_pkg.sv
// types for the sample output path of the converter
`include "adc_out_consts.svh"

package adc_out_pkg;

	// =============================================
	// output coding selected by the format strap
	typedef enum logic {
		FMT_TWOS,
		FMT_OFFSET
	} fmt_t;

	// =============================================
	// one sample word with its out-of-range flag
	typedef struct packed {
		logic                 over;
		logic [`WORD_W-1:0]   word;
	} sample_t;

endpackage

// >>> verilog/adc_sample_output_interface.sv
// sample coding, latency pipeline, output fifo and forwarded data clock
//
// What this block does
// - sample is taken on the rising edge of the conversion clock
// - word appears 11 conversion cycles after its sample, one more per word a receiver stall leaves in the fifo; receiver latches on rising clock
// - drive a true and complement data clock derived from the conversion clock
// - half_rate_select low divides the clock by two; high bypasses the divider
// - unconnected half_rate_select reads low, so divide-by-two is the default
// - 12-bit word, two's complement when format low, offset binary when high
// - unconnected format_select reads low, so two's complement is the default
// - overrange true high and comp low beyond either full scale, else opposite
// - offset binary: fff at +fs, 000 at -fs, 800 or 7ff at mid-scale
// - two's complement: 7ff at +fs, 800 at -fs, 000 or fff at mid-scale
// - inputs beyond full scale clamp to that full-scale code and set the flag
// - conversion clock always regenerated at 50% duty; source must exceed 20 MHz
// - bit 11 of the word is the msb, bit 0 the lsb
`timescale 1ns/1ps
`include "adc_out_consts.svh"

// =============================================
// sample fifo
module sample_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_n_in,
	// filling side
	input  wire logic             in_valid_in,
	output wire logic             in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// draining side
	output wire logic             out_valid_out,
	input  wire logic             out_ready_in,
	output wire logic [WIDTH-1:0] out_data_out
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;

	wire logic do_wr = in_valid_in & in_ready_out;
	wire logic do_rd = out_valid_out & out_ready_in;

	wire logic full  = (count_r == CNT_W'(DEPTH));
	wire logic empty = (count_r == '0);

	assign in_ready_out  = ~full;
	assign out_valid_out = ~empty;
	assign out_data_out  = mem_r[rd_ptr_r];

	// storage carries no reset; only pointers and count define state
	always_ff @(posedge clk_sys_in) begin
		if (do_wr) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
		end else if (do_wr) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_ptr_r <= '0;
		end else if (do_rd) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

	// full refuses a push even while popping; keeps ready off the pop path
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_r <= '0;
		end else if (do_wr && !do_rd) begin
			count_r <= count_r + 1'b1;
		end else if (do_rd && !do_wr) begin
			count_r <= count_r - 1'b1;
		end
	end
endmodule

// =============================================
// converter output block
module adc_sample_output_interface (
	// clock and reset
	input  wire logic                      clk_sys_in,
	input  wire logic                      rst_n_in,
	// quantised result from the analog front end
	input  wire logic signed [`CODE_W-1:0] conv_code_in,
	// strap and receiver pins
	input  wire logic                      half_rate_select_in,
	input  wire logic                      format_select_in,
	input  wire logic                      receiver_ready_in,
	// parallel sample bus
	output logic [`WORD_W-1:0]             sample_word_true_out,
	output logic [`WORD_W-1:0]             sample_word_comp_out,
	output logic                           overrange_true_out,
	output logic                           overrange_comp_out,
	// forwarded data clock
	output logic                           data_clock_out_true_out,
	output logic                           data_clock_out_comp_out,
	// status
	output logic                           sample_lost_out
);
	import adc_out_pkg::*;

	// =============================================
	// pin synchronisers
	logic [`PIN_W-1:0] pin_s1_r;
	logic [`PIN_W-1:0] pin_s2_r;
	logic [`PIN_W-1:0] pin_s3_r;
	logic [`PIN_W-1:0] pins_r;
	wire  logic [`PIN_W-1:0] pins_raw = {receiver_ready_in, format_select_in, half_rate_select_in};
	wire  logic [`PIN_W-1:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
	localparam logic [`PIN_W-1:0] PIN_INIT = `PIN_RESET;

	// reset value stands in for the pull-downs until the straps are seen
	genvar gp;
	generate
		for (gp = 0; gp < `PIN_W; gp++) begin : g_pin
			always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					pin_s1_r[gp] <= PIN_INIT[gp];
					pin_s2_r[gp] <= PIN_INIT[gp];
					pin_s3_r[gp] <= PIN_INIT[gp];
					pins_r[gp]   <= PIN_INIT[gp];
				end else begin
					pin_s1_r[gp] <= pins_raw[gp];
					pin_s2_r[gp] <= pin_s1_r[gp];
					pin_s3_r[gp] <= pin_s2_r[gp];
					if (pin_agree[gp]) begin
						pins_r[gp] <= pin_s3_r[gp];
					end
				end
			end
		end
	endgenerate

	wire logic half_rate = pins_r[`PIN_HALF];
	wire fmt_t fmt       = fmt_t'(pins_r[`PIN_FMT]);
	wire logic rx_ready  = pins_r[`PIN_RDY];

	// =============================================
	// conversion clock regeneration
	logic div_r;
	logic phase_r;

	// a phase toggled on ticks is always 50% duty whatever the source shape
	wire logic tick      = half_rate ? 1'b1 : div_r;
	wire logic div_nxt   = half_rate ? 1'b0 : ~div_r;
	wire logic phase_nxt = tick ? ~phase_r : phase_r;
	wire logic strobe    = tick & ~phase_r;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// =============================================
	// clamp and coding of the captured sample
	wire logic over_pos = conv_code_in > $signed(`CODE_POS_FS);
	wire logic over_neg = conv_code_in < $signed(`CODE_NEG_FS);

	wire logic [`WORD_W-1:0] twos_word =
		over_pos ? `POS_FS_TWOS :
		over_neg ? `NEG_FS_TWOS :
		conv_code_in[`WORD_W-1:0];

	// offset binary is two's complement with the msb inverted
	wire logic [`WORD_W-1:0] coded_word =
		(fmt == FMT_OFFSET) ? (twos_word ^ `MSB_FLIP) : twos_word;

	wire logic out_of_range = over_pos | over_neg;
	wire sample_t captured = '{over: out_of_range, word: coded_word};

	// =============================================
	// latency pipeline
	sample_t                 pipe_r [`PIPE_DEPTH];
	logic [`PIPE_DEPTH-1:0]  pipe_vld_r;
	logic                    fifo_in_ready;
	logic                    fifo_out_valid;
	sample_t                 fifo_out;

	// a full fifo freezes the pipe; the sample offered then is lost
	wire logic advance = strobe & fifo_in_ready;

	genvar gs;
	generate
		for (gs = 0; gs < `PIPE_DEPTH; gs++) begin : g_stage
			if (gs == 0) begin : g_head
				always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
					if (!rst_n_in) begin
						pipe_r[gs]     <= '0;
						pipe_vld_r[gs] <= 1'b0;
					end else if (advance) begin
						pipe_r[gs]     <= captured;
						pipe_vld_r[gs] <= 1'b1;
					end
				end
			end else begin : g_body
				always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
					if (!rst_n_in) begin
						pipe_r[gs]     <= '0;
						pipe_vld_r[gs] <= 1'b0;
					end else if (advance) begin
						pipe_r[gs]     <= pipe_r[gs-1];
						pipe_vld_r[gs] <= pipe_vld_r[gs-1];
					end
				end
			end
		end
	endgenerate

	// =============================================
	// output buffer
	wire logic push = advance & pipe_vld_r[`PIPE_DEPTH-1];
	wire logic pop  = strobe & rx_ready;

	sample_fifo #(
		.WIDTH ($bits(sample_t)),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (push),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (pipe_r[`PIPE_DEPTH-1]),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (pop),
		.out_data_out  (fifo_out)
	);

	wire logic load = pop & fifo_out_valid;

	// =============================================
	// output registers
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_word_true_out <= '0;
			sample_word_comp_out <= '1;
		end else if (load) begin
			sample_word_true_out <= fifo_out.word;
			sample_word_comp_out <= ~fifo_out.word;
		end
	end

	// flag loads with its own word, never on its own
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			overrange_true_out <= 1'b0;
			overrange_comp_out <= 1'b1;
		end else if (load) begin
			overrange_true_out <= fifo_out.over;
			overrange_comp_out <= ~fifo_out.over;
		end
	end

	// =============================================
	// forwarded data clock
	wire logic dclk_nxt = ~phase_nxt;

	// clock falls as data changes and rises mid-word for the receiver
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_clock_out_true_out <= 1'b1;
			data_clock_out_comp_out <= 1'b0;
		end else begin
			data_clock_out_true_out <= dclk_nxt;
			data_clock_out_comp_out <= ~dclk_nxt;
		end
	end

	// =============================================
	// status
	wire logic lost_nxt = strobe & ~fifo_in_ready;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_lost_out <= 1'b0;
		end else begin
			sample_lost_out <= lost_nxt;
		end
	end
endmodule

// >>> bench/adc_out_chk.sv
// checker on the sample output ports
`timescale 1ns/1ps
`include "adc_out_consts.svh"
module adc_out_chk (
	// clock, reset, pins
	input wire logic	clk_sys_in,
	input wire logic	rst_n_in,
	input wire logic	half_rate_select_in,
	input wire logic	receiver_ready_in,
	// outputs watched
	input wire logic [`WORD_W-1:0]	sample_word_true_out,
	input wire logic [`WORD_W-1:0]	sample_word_comp_out,
	input wire logic	overrange_true_out,
	input wire logic	overrange_comp_out,
	input wire logic	data_clock_out_true_out,
	input wire logic	data_clock_out_comp_out
);
	wire logic [`WORD_W-1:0]	w = sample_word_true_out;
	wire logic	dk = data_clock_out_true_out;
	wire logic	hs = half_rate_select_in;
	logic [3:0]	stall_r;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// =============================================
	// cycles the ready pin has been low, saturating
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stall_r <= 4'h0;
		end else if (receiver_ready_in) begin
			stall_r <= 4'h0;
		end else if (stall_r != 4'hf) begin
			stall_r <= stall_r + 4'h1;
		end
	end
	property p_comp; w == ~sample_word_comp_out; endproperty
	a_comp: assert property (p_comp) else $error("comp word");
	property p_orc; overrange_comp_out == !overrange_true_out; endproperty
	a_orc: assert property (p_orc) else $error("comp flag");
	property p_dkc; data_clock_out_comp_out == !dk; endproperty
	a_dkc: assert property (p_dkc) else $error("comp clock");
	property p_clamp; overrange_true_out |-> w inside {12'h7ff, 12'h800, 12'hfff, 12'h000};
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp code");
	property p_fall; $changed(w) |-> $fell(dk); endproperty
	a_fall: assert property (p_fall) else $error("word off clock");
	property p_flag; $changed(overrange_true_out) |-> $fell(dk); endproperty
	a_flag: assert property (p_flag) else $error("flag off clock");
	property p_div; !hs && !$past(hs, 8) && $rose(dk) |-> ##1 dk ##1 !dk; endproperty
	a_div: assert property (p_div) else $error("divide rate");
	property p_byp; hs && $past(hs, 8) && $rose(dk) |-> ##1 !dk ##1 dk; endproperty
	a_byp: assert property (p_byp) else $error("bypass rate");
	property p_hold; stall_r > 4'h5 |-> $stable(w); endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	c_over: cover property ($fell(overrange_true_out));
	c_stall: cover property (stall_r == 4'hf);
	c_byp: cover property (hs && $rose(dk));
endmodule
bind adc_sample_output_interface adc_out_chk u_chk (.clk_sys_in, .rst_n_in,
	.half_rate_select_in, .receiver_ready_in, .sample_word_true_out,
	.sample_word_comp_out, .overrange_true_out, .overrange_comp_out,
	.data_clock_out_true_out, .data_clock_out_comp_out);

// >>> bench/adc_rx_model.sv
// receiver latching words on the forwarded clock
`timescale 1ns/1ps
`include "adc_out_consts.svh"
module adc_rx_model (
	// sample bus
	input wire logic [`WORD_W-1:0]	word_in,
	input wire logic	over_in,
	input wire logic	dclk_in,
	// control and capture
	input wire logic	stall_in,
	output logic	ready_out,
	output logic [`WORD_W-1:0]	cap_word_out,
	output logic	cap_over_out
);
	assign ready_out = !stall_in;
	// rising edge: half a period after the bus moved
	always_ff @(posedge dclk_in) begin
		cap_word_out <= word_in;
		cap_over_out <= over_in;
	end
endmodule

// >>> bench/tb_adc_sample_output_interface.sv
// bench for the sample output block
`timescale 1ns/1ps
`include "adc_out_consts.svh"
module tb_adc_sample_output_interface;
	import adc_out_pkg::*;
	logic	clk_sys_in = 1'b0;
	logic	rst_n_in = 1'b0;
	logic signed [`CODE_W-1:0]	code = '0;
	logic	half = 1'b0, fmt = 1'b0, stall = 1'b0, rdy, ot, oc, dt, dc, lost, co;
	int	n_lost = 0;
	logic [`WORD_W-1:0]	wt, wc, cw;
	int	n_mismatch = 0, n_checks = 0, cyc = 0;
	always #20 clk_sys_in = ~clk_sys_in;
	adc_sample_output_interface uut (.clk_sys_in, .rst_n_in, .conv_code_in(code),
		.half_rate_select_in(half), .format_select_in(fmt), .receiver_ready_in(rdy),
		.sample_word_true_out(wt), .sample_word_comp_out(wc), .overrange_true_out(ot),
		.overrange_comp_out(oc), .data_clock_out_true_out(dt),
		.data_clock_out_comp_out(dc), .sample_lost_out(lost));
	adc_rx_model rx (.word_in(wt), .over_in(ot), .dclk_in(dt), .stall_in(stall),
		.ready_out(rdy), .cap_word_out(cw), .cap_over_out(co));
	task automatic chk_word(input logic [`WORD_W-1:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: word %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_flag(input logic g, e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: flag %b want %b", $time, g, e);
		end
	endtask
	task automatic chk_count(input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: count %0d want %0d", $time, g, e);
		end
	endtask
	task automatic results();
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard well above the whole run
	always @(posedge clk_sys_in) begin
		cyc++;
		if (lost === 1'b1) n_lost++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic t_rate(input logic h, input int e);
		time t0;
		@(posedge clk_sys_in) half <= h;
		repeat (40) @(posedge clk_sys_in);
		@(posedge dt) t0 = $time;
		@(posedge dt) chk_count(16'(($time - t0) / 40), 16'(e));
	endtask
	task automatic t_codes(input fmt_t f);
		logic signed [`CODE_W-1:0] ci [5] = '{14'sh0900, 14'sh07ff, 14'sh0000, 14'sh3800,
			14'sh3448};
		logic [`WORD_W-1:0] tw [5] = '{12'h7ff, 12'h7ff, 12'h000, 12'h800, 12'h800};
		@(posedge clk_sys_in) fmt <= f;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_sys_in) code <= ci[i];
			repeat (200) @(posedge clk_sys_in);
			chk_word(cw, f == FMT_OFFSET ? tw[i] ^ `MSB_FLIP : tw[i]);
			chk_flag(co, i == 0 || i == 4);
		end
	endtask
	// strobe count from a code change to the new word
	task automatic t_lat();
		int n = 0;
		logic p;
		logic [`WORD_W-1:0] w0;
		@(posedge clk_sys_in) code <= 14'sh0123;
		#1 p = dt;
		w0 = wt;
		repeat (60) begin
			@(posedge clk_sys_in);
			#1 if (p && !dt) n++;
			p = dt;
			if (wt !== w0) break;
		end
		chk_count(16'(n), 16'(`LATENCY + 1));
		chk_word(wt, 12'h123);
	endtask
	// fifo fills and drops while stalled, then drains until the new word reaches the receiver
	task automatic t_stall();
		logic [`WORD_W-1:0] w0;
		int n0;
		@(posedge clk_sys_in) stall <= 1'b1;
		repeat (10) @(posedge clk_sys_in);
		w0 = wt;
		n0 = n_lost;
		@(posedge clk_sys_in) code <= 14'sh0456;
		repeat (120) @(posedge clk_sys_in);
		chk_word(wt, w0);
		chk_flag(n_lost != n0, 1'b1);
		@(posedge clk_sys_in) stall <= 1'b0;
		repeat (200) @(posedge clk_sys_in);
		chk_word(cw, 12'h456);
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_in);
		chk_word(wc, 12'hfff);
		chk_flag(oc, 1'b1);
		chk_flag(dc, 1'b0);
		rst_n_in <= 1'b1;
		t_rate(1'b0, 4);
		t_codes(FMT_OFFSET);
		t_codes(FMT_TWOS);
		t_rate(1'b1, 2);
		t_lat();
		t_stall();
		results();
	end
endmodule
